// *** ehi_apb_regs.sv ***
`timescale 1ns/100ps
module ehi_apb_regs (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Block side
  output logic [25:0] mode_vec,
  input wire logic [3:0] enc_addr,
  output logic [31:0] enc_word,
  input wire logic [2:0] stat_bits,
  input wire logic [31:0] count_bits
);

  logic [31:0] enc_mem [0:15];

  wire acc = psel && penable && !pready;
  wire wr_now = psel && penable && pready && pwrite;
  wire hit_mode = paddr == ehi_pkg::REG_MODE;
  wire hit_stat = paddr == ehi_pkg::REG_STATUS;
  wire hit_cnt = paddr == ehi_pkg::REG_COUNT;
  wire hit_enc = paddr >= ehi_pkg::REG_ENCAP_BASE && paddr < ehi_pkg::REG_ENCAP_END
                 && paddr[1:0] == 2'h0;
  wire hit_any = hit_mode || hit_stat || hit_cnt || hit_enc;
  wire [31:0] rd_val = hit_mode ? {6'h00, mode_vec} :
                       hit_stat ? {29'h00000000, stat_bits} :
                       hit_cnt ? count_bits :
                       hit_enc ? enc_mem[paddr[5:2]] : 32'h00000000;

  assign enc_word = enc_mem[enc_addr];

  // ****************************************
  // One wait state, so read data leaves a flip-flop.
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      mode_vec <= ehi_pkg::MODE_RESET;
    end else begin
      pready <= acc;
      if (acc) begin
        prdata <= rd_val;
        pslverr <= !hit_any;
      end
      if (wr_now && hit_mode) begin
        mode_vec <= pwdata[25:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (wr_now && hit_enc) begin
      enc_mem[paddr[5:2]] <= pwdata;
    end
  end

endmodule // ehi_apb_regs

// *** ehi_crc32.sv ***
`timescale 1ns/100ps
module ehi_crc32 (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Byte feed
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] data,
  // Running remainder
  output logic [31:0] crc
);

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ ehi_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  always_ff @(posedge mclk) begin
    if (sys_rst || clr) begin
      crc <= ehi_pkg::CRC_INIT;
    end else if (en) begin
      crc <= crc_byte(crc, data);
    end
  end

endmodule // ehi_crc32

// *** ehi_pkg.sv ***
package ehi_pkg;

  // ****************************************
  // Stream and port geometry
  // ****************************************
  localparam int NUM_PORTS = 13;
  localparam logic [3:0] CPU_PORT_FIRST = 4'h0b;
  localparam int IFH_LEN = 16;
  localparam int MAC_LEN = 12;
  localparam int TAG_LEN = 4;
  localparam int ENCAP_LEN = 14;
  localparam int HDR_LEN = IFH_LEN + MAC_LEN;
  localparam logic [5:0] HDR_LAST = 6'(HDR_LEN - 1);
  localparam logic [5:0] PRE_LEN_NORMAL = 6'(MAC_LEN);
  localparam logic [5:0] PRE_LEN_KEEP = 6'(IFH_LEN + MAC_LEN);
  localparam logic [5:0] PRE_LEN_VTAG = 6'(MAC_LEN + TAG_LEN + IFH_LEN + MAC_LEN);
  localparam logic [5:0] PRE_LEN_ENCAP = 6'(ENCAP_LEN + IFH_LEN + MAC_LEN);
  localparam logic [5:0] VTAG_TAG_AT = 6'(MAC_LEN);
  localparam logic [5:0] VTAG_IFH_AT = 6'(MAC_LEN + TAG_LEN);
  localparam logic [5:0] VTAG_MAC_AT = 6'(MAC_LEN + TAG_LEN + IFH_LEN);
  localparam logic [5:0] ENCAP_MAC_AT = 6'(ENCAP_LEN + IFH_LEN);
  localparam logic [5:0] IFH_END = 6'(IFH_LEN);
  localparam logic [5:0] ENCAP_END = 6'(ENCAP_LEN);
  localparam logic [5:0] MAC_HALF = 6'h06;
  localparam logic [2:0] DLY_FULL = 3'h4;
  localparam logic [1:0] FCS_LAST = 2'h3;

  // ****************************************
  // Injection flags inside the header
  // ****************************************
  localparam int FLAG_BYTE = 0;
  localparam int BYPASS_BIT = 0;
  localparam int REFRESH_BIT = 1;
  localparam int EXCHANGE_BIT = 2;
  localparam int SMAC_CLR_BIT = 0;

  // Tag words inserted in vendor tag mode; both values are arbitrary.
  localparam logic [15:0] TAG_ETYPE = 16'h0abc;
  localparam logic [15:0] TAG_PROTO = 16'h0001;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] REG_MODE = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_COUNT = 12'h008;
  localparam logic [11:0] REG_ENCAP_BASE = 12'h040;
  localparam logic [11:0] REG_ENCAP_END = 12'h080;
  localparam logic [25:0] MODE_RESET = 26'h0000000;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;

  typedef enum logic [1:0] {
    HM_NORMAL = 2'b00,
    HM_KEEP = 2'b01,
    HM_VTAG = 2'b10,
    HM_ENCAP = 2'b11
  } ehi_hmode_t;

  typedef struct packed {
    logic [7:0] data;
    logic sof;
    logic eof;
  } ehi_beat_t;

endpackage

// *** ehi_rewriter.sv ***
// Notes on behaviour
// - Each port has a two-bit header mode; 0 drops header, 1-3 carry it.
// - Mode 1 sends header then frame with no rewriting of the frame.
// - Mode 2 sends DMAC, SMAC, tag type, tag protocol, header, frame.
// - Mode 3 sends a table encapsulation chosen by classifier index, header, frame.
// - With insertion on, every frame from that port carries the header.
// - Frames toward internal CPU ports always use mode 1.
// - Modes 2 and 3 compute FCS over the inserted header too.
// - Bypass flag forwards the frame unmodified, except requested FCS refresh.
// - Refresh flag recomputes the FCS even without other changes.
// - Exchange flag swaps DMAC and SMAC, then clears bit 40 of new SMAC.
// - Exchange forces FCS recompute; CPU never sets exchange with bypass.
`timescale 1ns/100ps
module ehi_rewriter (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // APB register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Frames from the switch core
  input wire logic in_valid,
  output logic in_ready,
  input wire ehi_pkg::ehi_beat_t in_beat,
  input wire logic [3:0] in_port,
  input wire logic [1:0] in_encap_idx,
  // Frames toward the egress port
  output logic out_valid,
  input wire logic out_ready,
  output ehi_pkg::ehi_beat_t out_beat
);

  typedef enum logic [1:0] {
    ST_HDR = 2'b00,
    ST_PRE = 2'b01,
    ST_BODY = 2'b10,
    ST_FCS = 2'b11
  } ehi_state_t;

  // ****************************************
  // State
  // ****************************************
  ehi_state_t state_ff;
  ehi_state_t nxt_state;
  logic [5:0] hcnt_ff;
  logic [5:0] pidx_ff;
  logic [1:0] fidx_ff;
  logic [2:0] dcnt_ff;
  logic [7:0] hdr_mem [0:ehi_pkg::HDR_LEN-1];
  logic [7:0] dly_ff [0:3];
  ehi_pkg::ehi_hmode_t mode_ff;
  logic [1:0] enc_ff;
  logic [15:0] frames_ff;
  logic [15:0] drops_ff;
  logic out_valid_ff;
  ehi_pkg::ehi_beat_t out_beat_ff;
  logic in_ready_ff;
  logic [25:0] mode_vec;
  logic [31:0] enc_word;
  logic [3:0] enc_addr;
  logic [31:0] crc;

  assign out_valid = out_valid_ff;
  assign out_beat = out_beat_ff;
  assign in_ready = in_ready_ff;

  // ****************************************
  // Register slave
  // ****************************************
  ehi_apb_regs u_regs (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .mode_vec(mode_vec),
    .enc_addr(enc_addr),
    .enc_word(enc_word),
    .stat_bits({mode_ff, state_ff != ST_HDR}),
    .count_bits({drops_ff, frames_ff})
  );

  // ****************************************
  // Mode lookup at start of frame
  // ****************************************
  function automatic ehi_pkg::ehi_hmode_t port_mode(input logic [3:0] p, input logic [25:0] v);
    logic [4:0] sh;
    sh = {p, 1'b0};
    if (p >= ehi_pkg::CPU_PORT_FIRST) begin
      return ehi_pkg::HM_KEEP;
    end
    return ehi_pkg::ehi_hmode_t'(v[sh +: 2]);
  endfunction

  wire take = in_valid && in_ready_ff;
  wire adv = !out_valid_ff || out_ready;
  wire [7:0] flag_byte = hdr_mem[ehi_pkg::FLAG_BYTE];
  wire flg_bypass = flag_byte[ehi_pkg::BYPASS_BIT];
  wire flg_refresh = flag_byte[ehi_pkg::REFRESH_BIT];
  // The injector must not pair exchange with bypass; if it does, bypass wins.
  wire swap_on = flag_byte[ehi_pkg::EXCHANGE_BIT] && !flg_bypass;
  wire wrapped = mode_ff == ehi_pkg::HM_VTAG || mode_ff == ehi_pkg::HM_ENCAP;
  wire recompute = wrapped || flg_refresh || swap_on;

  // ****************************************
  // Prefix layout per mode
  // ****************************************
  logic [5:0] pre_len;
  logic [1:0] seg;
  logic [5:0] rel;

  localparam logic [1:0] SEG_MAC = 2'h0;
  localparam logic [1:0] SEG_IFH = 2'h1;
  localparam logic [1:0] SEG_TAG = 2'h2;
  localparam logic [1:0] SEG_ENC = 2'h3;

  always_comb begin
    pre_len = ehi_pkg::PRE_LEN_NORMAL;
    seg = SEG_MAC;
    rel = pidx_ff;
    unique case (mode_ff)
      ehi_pkg::HM_NORMAL: begin
        pre_len = ehi_pkg::PRE_LEN_NORMAL;
      end
      ehi_pkg::HM_KEEP: begin
        pre_len = ehi_pkg::PRE_LEN_KEEP;
        if (pidx_ff < ehi_pkg::IFH_END) begin
          seg = SEG_IFH;
        end else begin
          rel = pidx_ff - ehi_pkg::IFH_END;
        end
      end
      ehi_pkg::HM_VTAG: begin
        pre_len = ehi_pkg::PRE_LEN_VTAG;
        if (pidx_ff >= ehi_pkg::VTAG_MAC_AT) begin
          rel = pidx_ff - ehi_pkg::VTAG_MAC_AT;
        end else if (pidx_ff >= ehi_pkg::VTAG_IFH_AT) begin
          seg = SEG_IFH;
          rel = pidx_ff - ehi_pkg::VTAG_IFH_AT;
        end else if (pidx_ff >= ehi_pkg::VTAG_TAG_AT) begin
          seg = SEG_TAG;
          rel = pidx_ff - ehi_pkg::VTAG_TAG_AT;
        end
      end
      ehi_pkg::HM_ENCAP: begin
        pre_len = ehi_pkg::PRE_LEN_ENCAP;
        if (pidx_ff >= ehi_pkg::ENCAP_MAC_AT) begin
          rel = pidx_ff - ehi_pkg::ENCAP_MAC_AT;
        end else if (pidx_ff >= ehi_pkg::ENCAP_END) begin
          seg = SEG_IFH;
          rel = pidx_ff - ehi_pkg::ENCAP_END;
        end else begin
          seg = SEG_ENC;
        end
      end
    endcase
  end

  // ****************************************
  // Prefix byte selection
  // ****************************************
  wire [5:0] mac_src = !swap_on ? rel :
                       (rel < ehi_pkg::MAC_HALF) ? rel + ehi_pkg::MAC_HALF :
                       rel - ehi_pkg::MAC_HALF;
  wire [5:0] mac_at = mac_src + 6'(ehi_pkg::IFH_LEN);
  wire [7:0] mac_raw = hdr_mem[mac_at[4:0]];
  wire clr_b40 = swap_on && rel == ehi_pkg::MAC_HALF;
  wire [7:0] mac_byte = clr_b40 ? (mac_raw & 8'hfe) : mac_raw;
  wire [31:0] tag_word = {ehi_pkg::TAG_ETYPE, ehi_pkg::TAG_PROTO};
  wire [4:0] tag_sh = {2'h3 - rel[1:0], 3'h0};
  wire [7:0] tag_byte = tag_word[tag_sh +: 8];
  assign enc_addr = {enc_ff, rel[3:2]};
  wire [7:0] enc_byte = enc_word[tag_sh +: 8];
  wire [7:0] ifh_byte = hdr_mem[rel[4:0]];
  wire [7:0] pre_byte = (seg == SEG_MAC) ? mac_byte :
                        (seg == SEG_IFH) ? ifh_byte :
                        (seg == SEG_TAG) ? tag_byte : enc_byte;
  // Mode 1 keeps the header outside the checksum, as an unwrapped frame.
  wire pre_cover = !(mode_ff == ehi_pkg::HM_KEEP && seg == SEG_IFH);
  wire pre_last = pidx_ff == pre_len - 6'h01;

  // ****************************************
  // Trailer selection
  // ****************************************
  wire [31:0] fcs_new = ~crc;
  wire [4:0] fcs_sh = {fidx_ff, 3'h0};
  wire [7:0] fcs_byte = recompute ? fcs_new[fcs_sh +: 8] : dly_ff[2'h3 - fidx_ff];

  // ****************************************
  // Output load and next state
  // ****************************************
  logic load;
  logic [7:0] ld_data;
  logic ld_sof;
  logic ld_eof;
  logic ld_cover;

  always_comb begin
    load = 1'b0;
    ld_data = pre_byte;
    ld_sof = 1'b0;
    ld_eof = 1'b0;
    ld_cover = 1'b0;
    nxt_state = state_ff;
    unique case (state_ff)
      ST_HDR: begin
        if (take && !in_beat.eof && hcnt_ff == ehi_pkg::HDR_LAST) begin
          nxt_state = ST_PRE;
        end
      end
      ST_PRE: begin
        if (adv) begin
          load = 1'b1;
          ld_sof = pidx_ff == 6'h00;
          ld_cover = pre_cover;
          if (pre_last) begin
            nxt_state = ST_BODY;
          end
        end
      end
      ST_BODY: begin
        if (take) begin
          load = dcnt_ff == ehi_pkg::DLY_FULL;
          ld_data = dly_ff[3];
          ld_cover = 1'b1;
          if (in_beat.eof) begin
            nxt_state = ST_FCS;
          end
        end
      end
      ST_FCS: begin
        if (adv) begin
          load = 1'b1;
          ld_data = fcs_byte;
          ld_eof = fidx_ff == ehi_pkg::FCS_LAST;
          if (ld_eof) begin
            nxt_state = ST_HDR;
          end
        end
      end
    endcase
  end

  wire nxt_out_valid = load || (out_valid_ff && !out_ready);
  wire accepts = nxt_state == ST_HDR || nxt_state == ST_BODY;
  // Input is offered only when the output stage is free next cycle, so a
  // taken body byte always has a place; this costs throughput, not data.
  wire nxt_in_ready = accepts && !take && !nxt_out_valid;

  ehi_crc32 u_crc (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clr(state_ff == ST_HDR),
    .en(load && ld_cover && state_ff != ST_FCS),
    .data(ld_data),
    .crc(crc)
  );

  // ****************************************
  // Sequencing
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_ff <= ST_HDR;
      hcnt_ff <= 6'h00;
      pidx_ff <= 6'h00;
      fidx_ff <= 2'h0;
      dcnt_ff <= 3'h0;
      mode_ff <= ehi_pkg::HM_NORMAL;
      enc_ff <= 2'h0;
      frames_ff <= 16'h0000;
      drops_ff <= 16'h0000;
      in_ready_ff <= 1'b0;
      out_valid_ff <= 1'b0;
      out_beat_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      in_ready_ff <= nxt_in_ready;
      out_valid_ff <= nxt_out_valid;
      if (load) begin
        out_beat_ff <= '{data: ld_data, sof: ld_sof, eof: ld_eof};
      end
      if (state_ff == ST_HDR && take) begin
        if ((hcnt_ff == 6'h00 && !in_beat.sof) || in_beat.eof) begin
          drops_ff <= drops_ff + 16'h0001;
          hcnt_ff <= 6'h00;
        end else begin
          hcnt_ff <= (hcnt_ff == ehi_pkg::HDR_LAST) ? 6'h00 : hcnt_ff + 6'h01;
          if (hcnt_ff == 6'h00) begin
            mode_ff <= port_mode(in_port, mode_vec);
            enc_ff <= in_encap_idx;
          end
        end
      end
      pidx_ff <= (state_ff != ST_PRE) ? 6'h00 : load ? pidx_ff + 6'h01 : pidx_ff;
      if (state_ff == ST_BODY && take && dcnt_ff != ehi_pkg::DLY_FULL) begin
        dcnt_ff <= dcnt_ff + 3'h1;
      end else if (state_ff != ST_BODY) begin
        dcnt_ff <= 3'h0;
      end
      if (state_ff == ST_FCS && load) begin
        fidx_ff <= fidx_ff + 2'h1;
        if (ld_eof) begin
          frames_ff <= frames_ff + 16'h0001;
        end
      end
    end
  end

  // ****************************************
  // Header capture and trailer delay line
  // ****************************************
  always_ff @(posedge mclk) begin
    if (state_ff == ST_HDR && take && !in_beat.eof) begin
      hdr_mem[hcnt_ff[4:0]] <= in_beat.data;
    end
  end

  // The last four body bytes are held back so the old FCS can be replaced.
  always_ff @(posedge mclk) begin
    if (state_ff == ST_BODY && take) begin
      dly_ff[3] <= dly_ff[2];
      dly_ff[2] <= dly_ff[1];
      dly_ff[1] <= dly_ff[0];
      dly_ff[0] <= in_beat.data;
    end
  end

endmodule // ehi_rewriter

// *** ehi_rewriter_props.sv ***
`timescale 1ns/100ps
module ehi_rewriter_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Frame streams
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire ehi_pkg::ehi_beat_t out_beat
);
  // ****************************************
  // Protocol properties
  // ****************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence one_wait;
    !pready ##1 pready;
  endsequence

  apb_one_wait_a: assert property (psel && $rose(penable) |-> one_wait)
    else $error("pready not after one wait state");
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  apb_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  err_read_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_beat))
    else $error("egress byte changed while stalled");
  in_gap_a: assert property (in_valid && in_ready |=> !in_ready)
    else $error("in_ready high right after a take");
  // A frame always carries at least the 12 MAC bytes, so it never ends on its first byte.
  frame_len_a: assert property (out_valid && out_beat.sof |-> !out_beat.eof)
    else $error("egress frame of one byte");
  reset_quiet_a: assert property (disable iff (1'b0) sys_rst |=> !out_valid && !in_ready)
    else $error("streams active during reset");
endmodule // ehi_rewriter_props

bind ehi_rewriter ehi_rewriter_props i_ehi_rewriter_props (.mclk, .sys_rst, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr, .in_valid, .in_ready, .out_valid, .out_ready, .out_beat);

// *** ehi_sink.sv ***
`timescale 1ns/100ps
module ehi_sink (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Bench control
  input wire logic stall,
  // Egress stream
  input wire logic out_valid,
  input wire ehi_pkg::ehi_beat_t out_beat,
  output logic out_ready = 1'b0
);
  // ****************************************
  // Receiver that takes every byte as data
  // ****************************************
  logic [7:0] got[$];
  logic [1:0] marks[$];
  logic [2:0] cnt_ff = 3'h0;

  // Bytes ahead of the MACs are not parsed, so a header in front is accepted.
  always @(posedge mclk) begin
    cnt_ff <= sys_rst ? 3'h0 : cnt_ff + 3'h1;
    out_ready <= !sys_rst && (!stall || cnt_ff[1]);
    if (!sys_rst && out_valid && out_ready) got.push_back(out_beat.data);
    if (!sys_rst && out_valid && out_ready) marks.push_back({out_beat.sof, out_beat.eof});
  end
endmodule // ehi_sink

// *** tb_ehi_rewriter.sv ***
`timescale 1ns/100ps
module tb_ehi_rewriter;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0, in_valid = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, in_ready, out_valid, out_ready;
  ehi_pkg::ehi_beat_t in_beat = '0;
  ehi_pkg::ehi_beat_t out_beat;
  logic [3:0] in_port = 4'h0;
  logic [1:0] in_encap_idx = 2'h0;
  int error_cnt = 0;
  int total_checks = 0;
  logic [7:0] in_q[$];
  logic [7:0] exp_q[$];

  ehi_rewriter i_ehi_rewriter (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .in_valid, .in_ready, .in_beat, .in_port, .in_encap_idx,
    .out_valid, .out_ready, .out_beat);
  ehi_sink i_ehi_sink (.mclk, .sys_rst, .stall, .out_valid, .out_beat, .out_ready);

  initial forever #12.5 mclk = ~mclk;

  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  function automatic logic [31:0] fcs_of(input logic [7:0] q[$], input int from);
    logic [31:0] c;
    c = ehi_pkg::CRC_INIT;
    for (int i = from; i < q.size(); i++) begin
      c ^= {24'h0, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ ehi_pkg::CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction

  task automatic run_frame(input logic [3:0] port, input logic [1:0] md,
                           input logic [1:0] idx, input logic [7:0] flg);
    logic [7:0] mac[12];
    logic [7:0] t;
    logic [31:0] f;
    in_q = {};
    exp_q = {};
    for (int i = 0; i < 16; i++) in_q.push_back(i == 0 ? flg : 8'h30 + 8'(i));
    for (int i = 0; i < 12; i++) mac[i] = 8'h41 + 8'(i);
    for (int i = 0; i < 12; i++) in_q.push_back(mac[i]);
    for (int i = 0; i < 10; i++) in_q.push_back(8'h90 + 8'(i));
    if (flg[2] && !flg[0]) begin
      for (int i = 0; i < 6; i++) begin
        t = mac[i];
        mac[i] = mac[i + 6];
        mac[i + 6] = t;
      end
      mac[6][0] = 1'b0;
    end
    if (md == 2'h2) begin
      for (int i = 0; i < 12; i++) exp_q.push_back(mac[i]);
      exp_q.push_back(ehi_pkg::TAG_ETYPE[15:8]);
      exp_q.push_back(ehi_pkg::TAG_ETYPE[7:0]);
      exp_q.push_back(ehi_pkg::TAG_PROTO[15:8]);
      exp_q.push_back(ehi_pkg::TAG_PROTO[7:0]);
    end
    if (md == 2'h3) for (int i = 0; i < 14; i++) exp_q.push_back(8'he0 + 8'(i));
    if (md != 2'h0) for (int i = 0; i < 16; i++) exp_q.push_back(in_q[i]);
    for (int i = 0; i < 12; i++) exp_q.push_back(mac[i]);
    for (int i = 0; i < 6; i++) exp_q.push_back(in_q[28 + i]);
    f = fcs_of(exp_q, md == 2'h1 ? 16 : 0);
    for (int i = 0; i < 4; i++)
      exp_q.push_back((md[1] || flg[1] || (flg[2] && !flg[0])) ? f[8 * i +: 8] : in_q[34 + i]);
    for (int i = 0; i < in_q.size(); i++) begin
      in_valid <= 1'b1;
      in_port <= port;
      in_encap_idx <= idx;
      in_beat <= {in_q[i], i == 0, i == in_q.size() - 1};
      do @(posedge mclk); while (in_ready !== 1'b1);
    end
    in_valid <= 1'b0;
    for (int n = 0; n < 3000 && i_ehi_sink.got.size() < exp_q.size(); n++) @(posedge mclk);
    repeat (4) @(posedge mclk);
    chk(i_ehi_sink.got.size(), exp_q.size(), "frame length");
    for (int i = 0; i < exp_q.size(); i++) chk(i_ehi_sink.got[i], exp_q[i], "frame byte");
    for (int i = 0; i < exp_q.size(); i++)
      chk(i_ehi_sink.marks[i], {i == 0, i == exp_q.size() - 1}, "frame marks");
    i_ehi_sink.got.delete();
    i_ehi_sink.marks.delete();
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_regs();
    logic [31:0] rd;
    logic err;
    apb(1'b0, ehi_pkg::REG_MODE, 32'h0, rd, err);
    chk(rd, 32'h0, "mode reset");
    apb(1'b1, ehi_pkg::REG_MODE, 32'h008000e4, rd, err);
    apb(1'b0, ehi_pkg::REG_MODE, 32'h0, rd, err);
    chk(rd, 32'h008000e4, "mode readback");
    chk(err, 32'h0, "mapped error");
    apb(1'b0, 12'h100, 32'h0, rd, err);
    chk(rd, 32'h0, "unmapped data");
    chk(err, 32'h1, "unmapped error");
    for (int w = 0; w < 4; w++)
      apb(1'b1, 12'h050 + 12'(4 * w), 32'he0e1e2e3 + {4{8'(4 * w)}}, rd, err);
  endtask

  task automatic test_modes();
    logic [31:0] rd;
    logic err;
    run_frame(4'h0, 2'h0, 2'h0, 8'h00);
    run_frame(4'h1, 2'h1, 2'h0, 8'h00);
    run_frame(4'h2, 2'h2, 2'h0, 8'h00);
    run_frame(4'h3, 2'h3, 2'h1, 8'h00);
    apb(1'b0, ehi_pkg::REG_STATUS, 32'h0, rd, err);
    chk(rd, {29'h0, ehi_pkg::HM_ENCAP, 1'b0}, "status mode");
    run_frame(4'hb, 2'h1, 2'h0, 8'h00);
  endtask

  // The far side stalls here; exchange is never combined with bypass.
  task automatic test_flags();
    logic [31:0] rd;
    logic err;
    stall <= 1'b1;
    run_frame(4'h1, 2'h1, 2'h0, 8'h03);
    run_frame(4'h0, 2'h0, 2'h0, 8'h02);
    run_frame(4'h4, 2'h0, 2'h0, 8'h04);
    apb(1'b0, ehi_pkg::REG_COUNT, 32'h0, rd, err);
    chk(rd, 32'h00000008, "frame count");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge mclk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    test_regs();
    test_modes();
    test_flags();
    give_verdict();
  end
endmodule // tb_ehi_rewriter
